// ==== inc/tsm_pkg.sv ====
// tsm_pkg: constants, register map and carrier types for the touch sense module control block
// assumes a 32-bit axi4-lite register bus and a 10 MHz system clock
package tsm_pkg;
	// register byte offsets, one aligned word each
	localparam logic [11:0] OFS_COUNT_LOW  = 12'h000;
	localparam logic [11:0] OFS_COUNT_HIGH = 12'h004;
	localparam logic [11:0] OFS_REFCAP_LOW = 12'h008;
	localparam logic [11:0] OFS_REFCAP_HI  = 12'h00c;
	localparam logic [11:0] OFS_CTRL0      = 12'h010;
	localparam logic [11:0] OFS_CTRL1      = 12'h014;
	localparam logic [11:0] OFS_GLOBAL     = 12'h018;
	localparam logic [11:0] OFS_NEXT_CAP   = 12'h01c;
	localparam logic [11:0] MOD_STRIDE     = 12'h040;
	localparam int          NUM_MODULES    = 2;
	// field positions
	localparam int C0_MUX_LSB   = 6;
	localparam int C0_DOUBLE    = 5;
	localparam int C0_FILTER    = 4;
	localparam int C0_HOP_HW    = 3;
	localparam int C1_SLOT_CLK  = 7;
	localparam int C1_REF_EN    = 5;
	localparam int C1_KEY_EN    = 4;
	localparam int GL_START     = 0;
	localparam int GL_OVF0      = 1;
	localparam int GL_SLOT_DONE = 3;
	localparam int GL_PRELOAD   = 8;
	// reset values and masks
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [7:0]  CTRL1_MASK   = 8'hbf;
	localparam logic [9:0]  REFCAP_RST   = 10'h000;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [7:0]  PRELOAD_RST  = 8'h00;
	localparam logic [4:0]  UNIT_LAST    = 5'h1f;
	localparam logic [1:0]  SYSDIV_LAST  = 2'h3;
	localparam int          REFCAP_FULL_PF = 50;
	localparam int          REFCAP_STEPS   = 1024;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef struct packed {
		logic [1:0] mux_sel;
		logic       freq_double_en;
		logic       filter_en;
		logic       hop_hw_control;
		logic [2:0] hop_freq_sel;
	} tsm_ctrl0_t;

	typedef struct packed {
		logic       slot_clock_sel;
		logic       unused6;
		logic       ref_osc_en;
		logic       key_osc_en;
		logic [3:0] pad_en;
	} tsm_ctrl1_t;

	// per-module analog control bundle
	typedef struct packed {
		logic [3:0] pad_en;
		logic       key_osc_run;
		logic       ref_osc_run;
		logic       freq_double_en;
		logic       filter_en;
		logic [2:0] hop_freq_sel;
		logic       hop_hw_control;
		logic [9:0] refcap_code;
	} tsm_analog_t;

	typedef enum logic [2:0] {
		TSM_IDLE = 3'b001,
		TSM_RUN  = 3'b010,
		TSM_DONE = 3'b100
	} tsm_state_t;
endpackage

// ==== hdl/tsm_top.sv ====
// tsm_top: two touch sense modules with counters, slot timers and axi4-lite registers
// assumes sense and reference oscillator edges arrive asynchronously as level toggles
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - each module's 16-bit sense count reads as low and high bytes, zero after reset.
// - sense counter freezes and holds its value when the time slot overflows.
// - sense count is forced to zero while the detect start bit is low.
// - 10-bit reference capacitor code, bits 9:8 high byte, 7:0 low byte, reset zero.
// - at slot end the capacitor code reloads from the next-slot value.
// - reference capacitance equals 50pF times code divided by 1024.
// - control 0 bits 7:6 route pad 1 to 4 to the counter.
// - control 0 bit 5 doubles the key oscillator frequency.
// - control 0 bit 4 enables the filter.
// - control 0 bit 3 hands hopping to hardware, ignoring the software field.
// - three-bit hop field picks one of eight frequencies, only when software controls.
// - control 1 bit 7 picks slot clock: reference oscillator or system clock over four.
// - control 1 bit 5 enables the reference oscillator.
// - control 1 bit 4 enables the key sense oscillators.
// - control 1 bits 3:0 assign pads 4 to 1 to touch sensing.
// - control 1 bit 6 and capacitor high bits 7:2 read zero, ignore writes.
// - a rising detect start switches on counters and oscillators.
// - slot lasts (256 minus preload) times 32 slot clock periods.
// - sense counter overflow sets a sticky flag only software clears.
module tsm_top
	import tsm_pkg::*;
(
	input  wire logic        aclk,            // system clock, 10 MHz
	input  wire logic        aresetn,         // synchronous reset, active low
	input  wire logic [11:0] s_axi_awaddr,    // write address
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	output logic [1:0]       s_axi_bresp,     // write response
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	input  wire logic [11:0] s_axi_araddr,    // read address
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	input  wire logic [3:0]  key_osc_tgl [2], // per-pad sense oscillator toggles
	input  wire logic        ref_osc_tgl [2], // reference oscillator toggles
	output tsm_analog_t      analog_ctrl [2], // oscillator and pad controls
	output logic             slot_done        // any slot ended, level until the detect start bit is cleared
);
	import tsm_pkg::*;

	// register state
	tsm_ctrl0_t  ctrl0_ff     [NUM_MODULES];
	tsm_ctrl1_t  ctrl1_ff     [NUM_MODULES];
	logic [9:0]  refcap_ff    [NUM_MODULES];
	logic [9:0]  next_cap_ff  [NUM_MODULES];
	logic [15:0] count_ff     [NUM_MODULES];
	logic        ovf_ff       [NUM_MODULES];
	logic [4:0]  unit_ff      [NUM_MODULES];
	logic [7:0]  slot_ff      [NUM_MODULES];
	logic [1:0]  sysdiv_ff    [NUM_MODULES];
	tsm_state_t  state_ff     [NUM_MODULES];
	logic [2:0]  key_sync_ff  [NUM_MODULES][4];
	logic [2:0]  ref_sync_ff  [NUM_MODULES];
	logic        start_ff;
	logic        start_d_ff;
	logic [7:0]  preload_ff;

	// bus handshake state
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;

	// writes with strobe 0 land in the low byte of each word
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
	                                      input logic s);
		return s ? d[7:0] : old;
	endfunction

	// module index and in-module offset of an address
	function automatic logic mod_of(input logic [11:0] a);
		return a[6];
	endfunction

	function automatic logic [11:0] ofs_of(input logic [11:0] a);
		return a & 12'h03f;
	endfunction

	wire logic        do_write   = aw_held_ff && w_held_ff && !s_axi_bvalid;
	wire logic [11:0] wofs       = ofs_of(awaddr_ff);
	wire logic        wmod       = mod_of(awaddr_ff);
	wire logic        wmapped    = (awaddr_ff[11:7] == 5'h00) && (wofs[1:0] == 2'b00)
	                               && (wofs <= OFS_NEXT_CAP);
	wire logic        start_rise = start_ff && !start_d_ff;

	// write channels: take address and data in either order, answer once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			awaddr_ff     <= 12'h000;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
			end
		end
	end

	// global start and preload word, shared by both modules
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_ff   <= 1'b0;
			start_d_ff <= 1'b0;
			preload_ff <= PRELOAD_RST;
		end else begin
			start_d_ff <= start_ff;
			if (do_write && wmapped && wofs == OFS_GLOBAL && !wmod) begin
				if (wstrb_ff[0])
					start_ff <= wdata_ff[GL_START];
				if (wstrb_ff[1])
					preload_ff <= wdata_ff[GL_PRELOAD +: 8];
			end
		end
	end

	// per-module logic
	for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
		wire logic sel = do_write && wmapped && (wmod == 1'(m));
		wire logic key_edge;
		wire logic ref_edge;
		wire logic slot_tick;
		wire logic sel_key_edge;
		logic      unit_wrap;

		// three-stage synchronisers; key change seen when stages two and three differ, reference counts rises only
		for (genvar k = 0; k < 4; k++) begin : g_ks
			always_ff @(posedge aclk) begin
				if (!aresetn)
					key_sync_ff[m][k] <= 3'b000;
				else
					key_sync_ff[m][k] <= {key_sync_ff[m][k][1:0], key_osc_tgl[m][k]};
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn)
				ref_sync_ff[m] <= 3'b000;
			else
				ref_sync_ff[m] <= {ref_sync_ff[m][1:0], ref_osc_tgl[m]};
		end

		// each toggle is one half period; doubling counts both halves
		assign key_edge = key_sync_ff[m][ctrl0_ff[m].mux_sel][2] ^
		                  key_sync_ff[m][ctrl0_ff[m].mux_sel][1];
		assign sel_key_edge = key_edge && (ctrl0_ff[m].freq_double_en ||
		                      key_sync_ff[m][ctrl0_ff[m].mux_sel][1]);
		assign ref_edge = ref_sync_ff[m][1] && !ref_sync_ff[m][2];
		// slot clock: reference oscillator or system clock over four
		assign slot_tick = ctrl1_ff[m].slot_clock_sel ? (sysdiv_ff[m] == SYSDIV_LAST)
		                   : (ref_edge && ctrl1_ff[m].ref_osc_en);

		// control registers; bit 6 of control 1 never stores
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl0_ff[m]    <= tsm_ctrl0_t'(CTRL_RST);
				ctrl1_ff[m]    <= tsm_ctrl1_t'(CTRL_RST);
				next_cap_ff[m] <= REFCAP_RST;
			end else if (sel) begin
				if (wofs == OFS_CTRL0)
					ctrl0_ff[m] <= tsm_ctrl0_t'(merge8(ctrl0_ff[m], wdata_ff, wstrb_ff[0]));
				if (wofs == OFS_CTRL1)
					ctrl1_ff[m] <= tsm_ctrl1_t'(merge8(ctrl1_ff[m], wdata_ff, wstrb_ff[0])
					               & CTRL1_MASK);
				if (wofs == OFS_NEXT_CAP && wstrb_ff[0])
					next_cap_ff[m][7:0] <= wdata_ff[7:0];
				if (wofs == OFS_NEXT_CAP && wstrb_ff[1])
					next_cap_ff[m][9:8] <= wdata_ff[9:8];
			end
		end

		// capacitor code: software writes, reload from next-slot value at slot end
		always_ff @(posedge aclk) begin
			if (!aresetn)
				refcap_ff[m] <= REFCAP_RST;
			else if (state_ff[m] == TSM_RUN && unit_wrap && slot_ff[m] == 8'hff)
				refcap_ff[m] <= next_cap_ff[m];
			else if (sel && wofs == OFS_REFCAP_LOW && wstrb_ff[0])
				refcap_ff[m][7:0] <= wdata_ff[7:0];
			else if (sel && wofs == OFS_REFCAP_HI && wstrb_ff[0])
				refcap_ff[m][9:8] <= wdata_ff[1:0];
		end

		// slot sequencer: 5-bit unit counter under an 8-bit preloaded slot counter
		always_comb unit_wrap = slot_tick && unit_ff[m] == UNIT_LAST;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				state_ff[m]  <= TSM_IDLE;
				unit_ff[m]   <= 5'h00;
				slot_ff[m]   <= PRELOAD_RST;
				sysdiv_ff[m] <= 2'h0;
			end else begin
				sysdiv_ff[m] <= sysdiv_ff[m] + 2'h1;
				unique case (state_ff[m])
					TSM_IDLE: begin
						unit_ff[m] <= 5'h00;
						if (start_rise) begin
							state_ff[m] <= TSM_RUN;
							slot_ff[m]  <= preload_ff;
						end
					end
					TSM_RUN: begin
						if (!start_ff) begin
							state_ff[m] <= TSM_IDLE;
						end else if (slot_tick) begin
							unit_ff[m] <= unit_ff[m] + 5'h01;
							if (unit_wrap) begin
								slot_ff[m] <= slot_ff[m] + 8'h01;
								if (slot_ff[m] == 8'hff)
									state_ff[m] <= TSM_DONE;
							end
						end
					end
					TSM_DONE: begin
						unit_ff[m] <= 5'h00;
						if (!start_ff)
							state_ff[m] <= TSM_IDLE;
					end
				endcase
			end
		end

		// sense counter: cleared by low start, frozen after slot end, wraps
		always_ff @(posedge aclk) begin
			if (!aresetn)
				count_ff[m] <= COUNT_RST;
			else if (!start_ff)
				count_ff[m] <= COUNT_RST;
			else if (state_ff[m] == TSM_RUN && ctrl1_ff[m].key_osc_en && sel_key_edge)
				count_ff[m] <= count_ff[m] + 16'h0001;
		end

		// overflow flag: hardware set wins over a software clear in the same cycle
		always_ff @(posedge aclk) begin
			if (!aresetn)
				ovf_ff[m] <= 1'b0;
			else if (start_ff && state_ff[m] == TSM_RUN && ctrl1_ff[m].key_osc_en
			         && sel_key_edge && count_ff[m] == 16'hffff)
				ovf_ff[m] <= 1'b1;
			else if (do_write && wmapped && wofs == OFS_GLOBAL && !wmod && wstrb_ff[0]
			         && !wdata_ff[GL_OVF0 + m])
				ovf_ff[m] <= 1'b0;
		end

		// analog controls; oscillators run only while the slot is active
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				analog_ctrl[m] <= '0;
			end else begin
				analog_ctrl[m].pad_en         <= ctrl1_ff[m].pad_en;
				analog_ctrl[m].key_osc_run    <= ctrl1_ff[m].key_osc_en
				                                 && state_ff[m] == TSM_RUN;
				analog_ctrl[m].ref_osc_run    <= ctrl1_ff[m].ref_osc_en
				                                 && state_ff[m] == TSM_RUN;
				analog_ctrl[m].freq_double_en <= ctrl0_ff[m].freq_double_en;
				analog_ctrl[m].filter_en      <= ctrl0_ff[m].filter_en;
				analog_ctrl[m].hop_hw_control <= ctrl0_ff[m].hop_hw_control;
				// the field is masked when hardware owns hopping
				analog_ctrl[m].hop_freq_sel   <= ctrl0_ff[m].hop_hw_control ? 3'h0
				                                 : ctrl0_ff[m].hop_freq_sel;
				// the analog side scales capacitance by code, 50pF full scale
				analog_ctrl[m].refcap_code    <= refcap_ff[m];
			end
		end
	end

	// read channel: one cycle to accept, one to answer
	always_ff @(posedge aclk) begin
		logic [11:0] o;
		logic        mi;
		o  = ofs_of(s_axi_araddr);
		mi = mod_of(s_axi_araddr);
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			if (s_axi_araddr[11:7] != 5'h00 || o[1:0] != 2'b00 || o > OFS_NEXT_CAP)
				s_axi_rresp <= RESP_SLVERR;
			else unique case (o)
				OFS_COUNT_LOW:  s_axi_rdata[7:0] <= count_ff[mi][7:0];
				OFS_COUNT_HIGH: s_axi_rdata[7:0] <= count_ff[mi][15:8];
				OFS_REFCAP_LOW: s_axi_rdata[7:0] <= refcap_ff[mi][7:0];
				OFS_REFCAP_HI:  s_axi_rdata[1:0] <= refcap_ff[mi][9:8];
				OFS_CTRL0:      s_axi_rdata[7:0] <= ctrl0_ff[mi];
				OFS_CTRL1:      s_axi_rdata[7:0] <= ctrl1_ff[mi];
				OFS_GLOBAL:     s_axi_rdata[15:0] <= {preload_ff, 4'h0,
				                    slot_done, ovf_ff[1], ovf_ff[0], start_ff};
				OFS_NEXT_CAP:   s_axi_rdata[9:0] <= next_cap_ff[mi];
				default:        s_axi_rdata <= 32'h0000_0000;
			endcase
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready;
		end
	end

	// slot end status seen by software and the system
	always_ff @(posedge aclk) begin
		if (!aresetn)
			slot_done <= 1'b0;
		else
			slot_done <= state_ff[0] == TSM_DONE || state_ff[1] == TSM_DONE;
	end
endmodule

// ==== dv/tsm_osc_model.sv ====
// tsm_osc_model: behavioural sense and reference oscillators for both modules
// assumes analog_ctrl comes straight from tsm_top; oscillators run free of aclk
`timescale 1ns/1ns
module tsm_osc_model
	import tsm_pkg::*;
#(
	parameter int KEY_HALF_NS = 150,
	parameter int REF_HALF_NS = 470
)(
	input  wire tsm_analog_t analog_ctrl [2], // oscillator and pad controls
	output logic [3:0]       key_osc_tgl [2], // per-pad sense levels
	output logic             ref_osc_tgl [2]  // reference levels
);
	// a disabled oscillator stands still at its last level, as the real one does
	initial begin
		key_osc_tgl = '{4'h0, 4'h0};
		ref_osc_tgl = '{1'b0, 1'b0};
		fork
			forever begin
				#KEY_HALF_NS;
				for (int m = 0; m < 2; m++) begin
					for (int p = 0; p < 4; p++) begin
						if (analog_ctrl[m].key_osc_run && analog_ctrl[m].pad_en[p]) begin
							key_osc_tgl[m][p] = ~key_osc_tgl[m][p];
						end
					end
				end
			end
			forever begin
				#REF_HALF_NS;
				for (int m = 0; m < 2; m++) begin
					if (analog_ctrl[m].ref_osc_run) begin
						ref_osc_tgl[m] = ~ref_osc_tgl[m];
					end
				end
			end
		join
	end
endmodule

// ==== dv/tsm_top_checker.sv ====
// tsm_top_checker: bus handshake and control output checks on tsm_top
// assumes it sees only the ports of tsm_top, attached by the bind below
`timescale 1ns/1ns
module tsm_top_checker
	import tsm_pkg::*;
(
	input wire logic        aclk,          // clock
	input wire logic        aresetn,       // reset, active low
	input wire logic [11:0] s_axi_awaddr,  // write address
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic [31:0] s_axi_wdata,   // write data
	input wire logic [3:0]  s_axi_wstrb,   // strobes
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic [1:0]  s_axi_bresp,   // write response
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic [11:0] s_axi_araddr,  // read address
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic [1:0]  s_axi_rresp,   // read response
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic        s_axi_rready,  // r ready
	input wire logic [3:0]  key_osc_tgl [2], // sense levels
	input wire logic        ref_osc_tgl [2], // reference levels
	input wire tsm_analog_t analog_ctrl [2], // analog controls
	input wire logic        slot_done        // slot finished
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// handshake steps of a write and a read
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// a response waits for the master and must not drop; read data must not change meanwhile
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved before taken");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	read_answer_a: assert property (rd_taken |-> ##1 s_axi_rvalid)
		else $error("read data late");
	// hardware hopping hides the software frequency field
	hop_masked_a: assert property (
		(!analog_ctrl[0].hop_hw_control || analog_ctrl[0].hop_freq_sel == 3'h0) &&
		(!analog_ctrl[1].hop_hw_control || analog_ctrl[1].hop_freq_sel == 3'h0))
		else $error("hop field passed under hardware control");
	reset_quiet_a: assert property ($rose(aresetn) |->
		analog_ctrl[0] == '0 && analog_ctrl[1] == '0 && !slot_done)
		else $error("outputs not cleared by reset");
	// the finished slot is only left by a register write, never on its own
	slot_hold_a: assert property ($fell(slot_done) && $past(aresetn) |->
		$past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4))
		else $error("slot end released without a write");
endmodule
bind tsm_top tsm_top_checker chk_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .key_osc_tgl(key_osc_tgl), .ref_osc_tgl(ref_osc_tgl),
	.analog_ctrl(analog_ctrl), .slot_done(slot_done)
);

// ==== dv/tb_top.sv ====
// tb_top: register and slot counting tests for tsm_top
// assumes tsm_osc_model stands in for the pads and oscillators
`timescale 1ns/1ns
module tb_top;
	import tsm_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} tsm_row_t;
	typedef struct {logic [7:0] c0; int lo; int hi;} tsm_run_t;
	logic        aclk, aresetn, slot_done;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [3:0]  key_osc_tgl [2];
	logic        ref_osc_tgl [2];
	tsm_analog_t analog_ctrl [2];
	int          num_errors, checked;
	// writes with the value each should read back
	tsm_row_t rows [6] = '{'{12'h010, 32'hff, 32'hff}, '{12'h014, 32'hff, 32'hbf},
		'{12'h00c, 32'hff, 32'h03}, '{12'h008, 32'ha5, 32'ha5},
		'{12'h004, 32'hff, 32'h00}, '{12'h050, 32'h5a, 32'h5a}};
	// 300 ns sense period over about 128 aclk gives some 43 edges, twice that doubled
	tsm_run_t runs [3] = '{'{8'h00, 36, 48}, '{8'h27, 72, 96}, '{8'h4f, 0, 0}};

	tsm_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_osc_tgl(key_osc_tgl),
		.ref_osc_tgl(ref_osc_tgl), .analog_ctrl(analog_ctrl), .slot_done(slot_done));
	tsm_osc_model osc_u (.analog_ctrl(analog_ctrl), .key_osc_tgl(key_osc_tgl),
		.ref_osc_tgl(ref_osc_tgl));

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic timeout();
		num_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		final_report();
	endtask

	// the leading edge lets the previous release land before a new request
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n > 300) timeout();
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 300) timeout();
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rd_count(output logic [15:0] c);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(OFS_COUNT_LOW, d, r);
		c[7:0] = d[7:0];
		axi_rd(OFS_COUNT_HIGH, d, r);
		c[15:8] = d[7:0];
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] c, c2;
		int          n;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		num_errors = 0;
		checked = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// the first six module 0 registers, offsets 0x00 to 0x14, read zero out of reset
		for (int i = 0; i < 6; i++) begin
			axi_rd(12'(4 * i), d, r);
			check(d, 32'h0);
		end
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].d);
			axi_rd(rows[i].a, d, r);
			check(d, rows[i].e);
		end
		check(32'({analog_ctrl[0].pad_en, analog_ctrl[0].freq_double_en, analog_ctrl[0].filter_en,
			analog_ctrl[0].hop_hw_control, analog_ctrl[0].refcap_code}),
			32'({4'hf, 3'h7, 10'h3a5}));
		// an address past the module window is refused and reads zero
		axi_rd(12'h080, d, r);
		check({d[29:0], r}, {30'h0, RESP_SLVERR});
		// a write outside the window is answered with an error and stores nothing
		axi_wr(12'h080, 32'h1);
		check(32'(s_axi_bresp), 32'(RESP_SLVERR));
		// divided system clock keeps the slot valid without the reference oscillator
		axi_wr(OFS_CTRL1, 32'h91);
		axi_wr(OFS_NEXT_CAP, 32'h155);
		foreach (runs[k]) begin
			axi_wr(OFS_CTRL0, {24'h0, runs[k].c0});
			axi_wr(OFS_GLOBAL, 32'h0000ff01);
			n = 0;
			while (slot_done !== 1'b1) begin
				@(posedge aclk);
				n++;
				if (n > 400) timeout();
			end
			check(32'(n >= 118 && n <= 140), 32'h1);
			rd_count(c);
			check(32'(c >= runs[k].lo && c <= runs[k].hi), 32'h1);
			repeat (20) @(posedge aclk);
			rd_count(c2);
			check({16'h0, c2}, {16'h0, c});
			check(32'(analog_ctrl[0].refcap_code), 32'h155);
			check(32'(analog_ctrl[0].hop_freq_sel), runs[k].c0[3] ? 32'h0 : 32'(runs[k].c0[2:0]));
			axi_wr(OFS_GLOBAL, 32'h0000ff00);
			rd_count(c);
			check({16'h0, c}, 32'h0);
		end
		final_report();
	end
endmodule
